// file: design/mrc_cfg.svh
// Offsets, field positions and reset values of the mode and regulator registers
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

// ==========================================================
// Bus geometry
`define MRC_ADDR_W 8
`define MRC_DATA_W 24

// ==========================================================
// Register offsets (byte addresses)
`define MRC_OFS_MODE 8'h00
`define MRC_OFS_REGCTL 8'h04

// ==========================================================
// Mode register fields
`define MRC_B_LOCK 16
`define MRC_B_EXTSEL 15
`define MRC_B_EXTOFF 14
`define MRC_B_NORMAL 13
`define MRC_B_WK2MASK 10
`define MRC_B_WK1MASK 9
`define MRC_B_STBY 8

// ==========================================================
// Regulator control register fields
`define MRC_B_PDOFF 23
`define MRC_B_PRE_OFF 22
`define MRC_B_CORE_OFF 20
`define MRC_B_SEC_OFF 18
`define MRC_B_LIN_OFF 17
`define MRC_B_PRE_ON 14
`define MRC_B_CORE_ON 12
`define MRC_B_SEC_ON 10
`define MRC_B_LIN_ON 9

// ==========================================================
// Reset values and strobe count
`define MRC_MASK_RST 1'b0
`define MRC_PDOFF_RST 1'b0
`define MRC_READ_ZERO 24'h00_0000
`define MRC_NUM_STROBES 10

`endif

// file: design/mrc_pkg.sv
// Types shared by the mode and regulator control register files
package mrc_pkg;

    // ==========================================================
    // Bus types
    typedef logic [7:0] mrc_addr_t;
    typedef logic [23:0] mrc_word_t;

    // ==========================================================
    // Main state tracked by the register block
    typedef enum logic [0:0] {
        MRC_ST_NORMAL,
        MRC_ST_STANDBY
    } mrc_state_e;

endpackage : mrc_pkg

// file: design/mrc_pulse_bank.sv
// Bank of registered one-cycle request strobes
`timescale 1ns/100ps
`include "mrc_cfg.svh"

module mrc_pulse_bank #(
    parameter int N = 10 // Number of strobes
) (
    input wire logic ref_clk_i, // System clock
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic [N-1:0] fire_i, // Write of a 1 this cycle
    output logic [N-1:0] pulse_o // One-cycle request pulses
);

    // ==========================================================
    // Strobe flops: never held, so nothing is stored
    logic [N-1:0] pulse_r; // Registered strobes

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_strobe
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    pulse_r[g] <= 1'b0;
                end else begin
                    pulse_r[g] <= fire_i[g];
                end
            end
        end
    endgenerate

    assign pulse_o = pulse_r;

endmodule : mrc_pulse_bank

// file: design/mrc_regs.sv
// Mode control/status and regulator enable control register block
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "mrc_cfg.svh"

module mrc_regs (
    input wire logic ref_clk_i, // System clock, 50 MHz
    input wire logic reset_i, // Synchronous reset, active high
    input wire mrc_pkg::mrc_addr_t addr_i, // Register byte address
    input wire mrc_pkg::mrc_word_t wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output mrc_pkg::mrc_word_t rdata_o, // Read data, cycle after rd_i
    input wire logic loop_lock_live_i, // Loop lock pin
    input wire logic external_clock_chosen_live_i, // Clock source pin
    input wire logic wake_input_one_i, // First wake pin
    input wire logic wake_input_two_i, // Second wake pin
    output logic external_clock_select_off_req_o, // Drop external clock
    output logic standby_entry_req_o, // Standby entry pulse
    output logic main_normal_o, // Main state is Normal
    output logic wake_event_o, // Accepted wake pulse
    output logic wake_input_one_mask_o, // First wake masked
    output logic wake_input_two_mask_o, // Second wake masked
    output logic prereg_pulldown_off_o, // Pull-down forced off
    output logic prereg_off_req_o, // Pre-regulator off pulse
    output logic core_buck_off_req_o, // Core buck off pulse
    output logic second_buck_off_req_o, // Second buck off pulse
    output logic linear_reg_off_req_o, // Linear regulator off pulse
    output logic prereg_on_req_o, // Pre-regulator on pulse
    output logic core_buck_on_req_o, // Core buck on pulse
    output logic second_buck_on_req_o, // Second buck on pulse
    output logic linear_reg_on_req_o // Linear regulator on pulse
);

    import mrc_pkg::*;
    // Everything runs on ref_clk_i; reset is synchronous and active high

    // ==========================================================
    // Address decode helper

    // True when the address selects the given offset
    // Exact compare: any other address neither writes nor reads
    function automatic logic addr_hit(input mrc_addr_t a, input mrc_addr_t ofs);
        addr_hit = (a == ofs);
    endfunction : addr_hit

    // ==========================================================
    // Declarations

    // Access decode
    logic sel_mode; // Mode register addressed
    logic sel_regctl; // Regulator register addressed
    logic wr_mode; // Write to mode register
    logic wr_regctl; // Write to regulator register

    // Stored control bits
    logic wk1_mask_r; // First wake mask
    logic wk2_mask_r; // Second wake mask
    logic pdoff_r; // Pull-down force off

    // Synchronised pins
    logic [3:0] pin_raw; // Raw pin vector
    logic [3:0] pin_lvl; // Filtered pin vector
    logic lock_lvl; // Loop locked
    logic extsel_lvl; // External clock chosen
    logic wk1_lvl; // First wake level
    logic wk2_lvl; // Second wake level

    // Main state tracking
    mrc_state_e state_r; // Current main state
    mrc_state_e state_nxt; // Next main state
    logic wake_hit; // Unmasked wake seen
    logic wake_ev_r; // Wake pulse flop
    logic wake_ev_nxt; // Wake pulse next
    logic in_normal; // Main state decodes as Normal

    // Strobes
    // Index 0..1: mode register requests (clock drop, standby)
    // Index 2..5: regulator off requests (pre, core, second, linear)
    // Index 6..9: regulator on requests (pre, core, second, linear)
    logic [`MRC_NUM_STROBES-1:0] fire; // Strobe requests now
    logic [`MRC_NUM_STROBES-1:0] pulse; // Registered strobes

    // Read path
    mrc_word_t mode_view; // Mode register read image
    mrc_word_t regctl_view; // Regulator register read image
    mrc_word_t rd_mux; // Selected read image
    mrc_word_t rdata_r; // Read data flop

    // ==========================================================
    // Access decode

    assign sel_mode = addr_hit(addr_i, `MRC_OFS_MODE);
    assign sel_regctl = addr_hit(addr_i, `MRC_OFS_REGCTL);
    assign wr_mode = wr_i & sel_mode;
    assign wr_regctl = wr_i & sel_regctl;

    // ==========================================================
    // Pin synchronisers

    // Status and wake pins arrive from outside the clock domain
    // A pin change shows in the read image three edges after it is first sampled,
    // and a level seen by only one sample is never accepted
    assign pin_raw = {wake_input_two_i, wake_input_one_i,
                      external_clock_chosen_live_i, loop_lock_live_i};

    mrc_sync3 #(
        .W(4)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .pin_i(pin_raw),
        .level_o(pin_lvl)
    );

    // Split the filtered vector back into named levels
    assign lock_lvl = pin_lvl[0];
    assign extsel_lvl = pin_lvl[1];
    assign wk1_lvl = pin_lvl[2];
    assign wk2_lvl = pin_lvl[3];

    // ==========================================================
    // Stored control bits

    // Wake masks, cleared at reset, written with the mode register
    // Masks are written on every mode write, so writing 0 unmasks
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wk1_mask_r <= `MRC_MASK_RST;
            wk2_mask_r <= `MRC_MASK_RST;
        end else if (wr_mode) begin
            wk1_mask_r <= wdata_i[`MRC_B_WK1MASK];
            wk2_mask_r <= wdata_i[`MRC_B_WK2MASK];
        end
    end

    // Pull-down force off, written with the regulator register
    // Level only; the pull-down itself is driven outside this block
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pdoff_r <= `MRC_PDOFF_RST;
        end else if (wr_regctl) begin
            pdoff_r <= wdata_i[`MRC_B_PDOFF];
        end
    end

    // ==========================================================
    // Request strobes

    // A written 1 fires a strobe; a written 0 does nothing
    // Mode register requests
    assign fire[0] = wr_mode & wdata_i[`MRC_B_EXTOFF];
    assign fire[1] = wr_mode & wdata_i[`MRC_B_STBY];
    // Regulator off requests
    assign fire[2] = wr_regctl & wdata_i[`MRC_B_PRE_OFF];
    assign fire[3] = wr_regctl & wdata_i[`MRC_B_CORE_OFF];
    assign fire[4] = wr_regctl & wdata_i[`MRC_B_SEC_OFF];
    assign fire[5] = wr_regctl & wdata_i[`MRC_B_LIN_OFF];
    // Regulator on requests
    assign fire[6] = wr_regctl & wdata_i[`MRC_B_PRE_ON];
    assign fire[7] = wr_regctl & wdata_i[`MRC_B_CORE_ON];
    assign fire[8] = wr_regctl & wdata_i[`MRC_B_SEC_ON];
    assign fire[9] = wr_regctl & wdata_i[`MRC_B_LIN_ON];

    // Strobes last one cycle and are never stored
    // Registering them keeps the requests glitch free downstream
    mrc_pulse_bank #(
        .N(`MRC_NUM_STROBES)
    ) u_pulses (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .fire_i(fire),
        .pulse_o(pulse)
    );

    // ==========================================================
    // Main state tracking

    // Only reset or an unmasked wake input can bring the block back
    // Wake is level sensitive: a level still high on Standby entry wakes at once
    assign wake_hit = (wk1_lvl & ~wk1_mask_r) | (wk2_lvl & ~wk2_mask_r);

    // Standby entry on request, return to Normal on wake
    always_comb begin
        state_nxt = state_r;
        wake_ev_nxt = 1'b0;
        case (state_r)
            MRC_ST_NORMAL: begin
                // Standby request leaves Normal
                if (fire[1]) begin
                    state_nxt = MRC_ST_STANDBY;
                end
            end
            MRC_ST_STANDBY: begin
                // A standby request here is ignored; its pulse still goes out
                // Wake returns to Normal
                if (wake_hit) begin
                    state_nxt = MRC_ST_NORMAL;
                    wake_ev_nxt = 1'b1;
                end
            end
            default: begin
                // Unknown encoding recovers to Normal
                state_nxt = MRC_ST_NORMAL;
            end
        endcase
    end

    // State flop: reset lands in Normal so the status reads 1
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_r <= MRC_ST_NORMAL;
            wake_ev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wake_ev_r <= wake_ev_nxt;
        end
    end

    // Normal decode shared by the status bit and the status output
    assign in_normal = (state_r == MRC_ST_NORMAL);

    // ==========================================================
    // Read images

    // Mode register: live status, masks; request bits read zero
    always_comb begin
        // Reserved and request bits stay zero
        mode_view = `MRC_READ_ZERO;
        mode_view[`MRC_B_LOCK] = lock_lvl;
        mode_view[`MRC_B_EXTSEL] = extsel_lvl;
        mode_view[`MRC_B_NORMAL] = in_normal;
        mode_view[`MRC_B_WK2MASK] = wk2_mask_r;
        mode_view[`MRC_B_WK1MASK] = wk1_mask_r;
    end

    // Regulator register: only the pull-down bit reads back
    always_comb begin
        // Enable and disable requests are strobes and read zero
        regctl_view = `MRC_READ_ZERO;
        regctl_view[`MRC_B_PDOFF] = pdoff_r;
    end

    // Unmapped addresses read zero
    // Priority does not matter: the two offsets never match together
    assign rd_mux = sel_mode ? mode_view :
                    sel_regctl ? regctl_view : `MRC_READ_ZERO;

    // ==========================================================
    // Read data flop

    // Data stands only in the cycle after the read strobe
    // Clearing between reads keeps a stale image off the bus
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_r <= `MRC_READ_ZERO;
        end else if (rd_i) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= `MRC_READ_ZERO;
        end
    end

    // ==========================================================
    // Outputs

    // Read data
    assign rdata_o = rdata_r;

    // Mode register request strobes
    assign external_clock_select_off_req_o = pulse[0];
    assign standby_entry_req_o = pulse[1];

    // Regulator request strobes
    assign prereg_off_req_o = pulse[2];
    assign core_buck_off_req_o = pulse[3];
    assign second_buck_off_req_o = pulse[4];
    assign linear_reg_off_req_o = pulse[5];
    assign prereg_on_req_o = pulse[6];
    assign core_buck_on_req_o = pulse[7];
    assign second_buck_on_req_o = pulse[8];
    assign linear_reg_on_req_o = pulse[9];

    // Main state and stored levels
    assign main_normal_o = in_normal;
    assign wake_event_o = wake_ev_r;
    assign wake_input_one_mask_o = wk1_mask_r;
    assign wake_input_two_mask_o = wk2_mask_r;
    assign prereg_pulldown_off_o = pdoff_r;

endmodule : mrc_regs

// file: design/mrc_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
`include "mrc_cfg.svh"

module mrc_sync3 #(
    parameter int W = 4 // Number of pins
) (
    input wire logic ref_clk_i, // System clock
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic [W-1:0] pin_i, // Asynchronous pin levels
    output logic [W-1:0] level_o // Filtered levels
);

    // ==========================================================
    // Stages
    logic [W-1:0] s1_r; // First stage, read only by second
    logic [W-1:0] s2_r; // Second stage
    logic [W-1:0] s3_r; // Third stage
    logic [W-1:0] level_r; // Accepted level

    // Shift chain and accept a change once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    level_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= pin_i[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        level_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    assign level_o = level_r;

endmodule : mrc_sync3

// file: verif/mrc_regs_props.sv
// Concurrent checks on the ports of the mode and regulator register block
`timescale 1ns/100ps

// ==========================================================
// Checker
module mrc_regs_props (
    input wire logic ref_clk_i, // Clock
    input wire logic reset_i, // Reset
    input wire mrc_pkg::mrc_addr_t addr_i, // Address
    input wire mrc_pkg::mrc_word_t wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire mrc_pkg::mrc_word_t rdata_o, // Read data
    input wire logic external_clock_select_off_req_o, // Clock drop pulse
    input wire logic standby_entry_req_o, // Standby pulse
    input wire logic main_normal_o, // Normal state
    input wire logic wake_input_one_mask_o, // Mask one
    input wire logic wake_input_two_mask_o, // Mask two
    input wire logic prereg_pulldown_off_o, // Pull-down off
    input wire logic prereg_off_req_o, // Off pulse
    input wire logic core_buck_off_req_o, // Off pulse
    input wire logic second_buck_off_req_o, // Off pulse
    input wire logic linear_reg_off_req_o, // Off pulse
    input wire logic prereg_on_req_o, // On pulse
    input wire logic core_buck_on_req_o, // On pulse
    input wire logic second_buck_on_req_o, // On pulse
    input wire logic linear_reg_on_req_o // On pulse
);
    import mrc_pkg::*;
    wire wm = wr_i && (addr_i == 8'h00); // Mode write
    wire wg = wr_i && (addr_i == 8'h04); // Regulator write
    wire [3:0] offs = {prereg_off_req_o, core_buck_off_req_o, second_buck_off_req_o,
        linear_reg_off_req_o}; // Off pulses
    wire [3:0] ons = {prereg_on_req_o, core_buck_on_req_o, second_buck_on_req_o,
        linear_reg_on_req_o}; // On pulses
    wire [1:0] masks = {wake_input_two_mask_o, wake_input_one_mask_o}; // Masks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ==========================================================
    // Assertions
    ext_off_pulse_a: assert property (
        wm |=> external_clock_select_off_req_o == $past(wdata_i[14]))
        else $error("clock drop pulse wrong");
    stby_entry_a: assert property (
        wm && wdata_i[8] |=> standby_entry_req_o && !main_normal_o)
        else $error("standby entry missing");
    mode_strobe_idle_a: assert property (
        !wm |=> !external_clock_select_off_req_o && !standby_entry_req_o)
        else $error("stray mode request pulse");
    mask_write_a: assert property (wm |=> masks == $past(wdata_i[10:9]))
        else $error("wake masks not written");
    mask_hold_a: assert property (!wm |=> $stable(masks))
        else $error("wake masks changed");
    pd_write_a: assert property (wg |=> prereg_pulldown_off_o == $past(wdata_i[23]))
        else $error("pull-down bit wrong");
    off_pulses_a: assert property (
        wg |=> offs == $past({wdata_i[22], wdata_i[20], wdata_i[18], wdata_i[17]}))
        else $error("off pulses wrong");
    on_pulses_a: assert property (
        wg |=> ons == $past({wdata_i[14], wdata_i[12], wdata_i[10], wdata_i[9]}))
        else $error("on pulses wrong");
    idle_pulses_a: assert property (!wg |=> offs == 4'h0 && ons == 4'h0)
        else $error("stray regulator pulse");
    mode_read_a: assert property (
        rd_i && addr_i == 8'h00 |=> rdata_o[13] == $past(main_normal_o)
            && (rdata_o & 24'hFE_59FF) == 24'h00_0000)
        else $error("mode read image wrong");
    reg_read_a: assert property (
        rd_i && addr_i == 8'h04 |=> rdata_o == {$past(prereg_pulldown_off_o), 23'h00_0000})
        else $error("regulator read image wrong");
    idle_read_a: assert property (!rd_i |=> rdata_o == 24'h00_0000)
        else $error("read data outside read slot");
    cov_stby_c: cover property (wm && wdata_i[8]);
    cov_regw_c: cover property (wg && wdata_i[22]);
    cov_read_c: cover property (rd_i && addr_i == 8'h00);
endmodule : mrc_regs_props

bind mrc_regs mrc_regs_props i_mrc_regs_props (.*);

// file: verif/mrc_regs_tb.sv
// Self-checking bench for the mode and regulator register block
`timescale 1ns/100ps

module tb;
    import mrc_pkg::*;
    logic ref_clk_i = 1'b0; // Clock
    logic reset_i = 1'b1; // Reset
    mrc_addr_t addr_i = 8'h00; // Address
    mrc_word_t wdata_i = 24'h00_0000; // Write data
    logic wr_i = 1'b0; // Write strobe
    logic rd_i = 1'b0; // Read strobe
    logic lock_i = 1'b1; // Loop lock pin
    logic ext_i = 1'b0; // Clock source pin
    logic wk1_i = 1'b0; // Wake pin one
    logic wk2_i = 1'b0; // Wake pin two
    mrc_word_t rdata_o; // Read data
    logic ext_o, stby_o, norm_o, wev_o, m1_o, m2_o, pd_o; // Outputs
    logic [3:0] off_o, on_o; // Regulator pulses
    wire [12:0] outs = {ext_o, stby_o, m1_o, m2_o, pd_o, off_o, on_o}; // Output image
    int n_mismatch = 0; // Mismatches
    int checked = 0; // Comparisons
    int cyc = 0; // Cycle counter
    mrc_word_t got; // Read result
    typedef struct {mrc_addr_t a; mrc_word_t d; logic [12:0] o; mrc_word_t r;} mrc_row_s;
    mrc_row_s rows [14] = '{
        '{8'h04, 24'h80_0000, 13'h0100, 24'h80_0000}, '{8'h04, 24'h40_0000, 13'h0080, 24'h00_0000},
        '{8'h04, 24'h10_0000, 13'h0040, 24'h00_0000}, '{8'h04, 24'h04_0000, 13'h0020, 24'h00_0000},
        '{8'h04, 24'h02_0000, 13'h0010, 24'h00_0000}, '{8'h04, 24'h00_4000, 13'h0008, 24'h00_0000},
        '{8'h04, 24'h00_1000, 13'h0004, 24'h00_0000}, '{8'h04, 24'h00_0400, 13'h0002, 24'h00_0000},
        '{8'h04, 24'h00_0200, 13'h0001, 24'h00_0000}, '{8'h04, 24'hFF_FFFF, 13'h01FF, 24'h80_0000},
        '{8'h00, 24'h00_4000, 13'h1100, 24'h01_2000}, '{8'h00, 24'h00_0600, 13'h0700, 24'h01_2600},
        '{8'h00, 24'h00_0200, 13'h0500, 24'h01_2200}, '{8'h08, 24'hFF_FFFF, 13'h0500, 24'h00_0000}};

    mrc_regs i_mrc_regs (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .loop_lock_live_i(lock_i), .external_clock_chosen_live_i(ext_i),
        .wake_input_one_i(wk1_i), .wake_input_two_i(wk2_i),
        .external_clock_select_off_req_o(ext_o), .standby_entry_req_o(stby_o),
        .main_normal_o(norm_o), .wake_event_o(wev_o), .wake_input_one_mask_o(m1_o),
        .wake_input_two_mask_o(m2_o), .prereg_pulldown_off_o(pd_o),
        .prereg_off_req_o(off_o[3]), .core_buck_off_req_o(off_o[2]),
        .second_buck_off_req_o(off_o[1]), .linear_reg_off_req_o(off_o[0]),
        .prereg_on_req_o(on_o[3]), .core_buck_on_req_o(on_o[2]),
        .second_buck_on_req_o(on_o[1]), .linear_reg_on_req_o(on_o[0]));

    // ==========================================================
    // Clock and cycle ceiling
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Bus and compare tasks
    task automatic wr(input mrc_addr_t a, input mrc_word_t d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input mrc_addr_t a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask : rd
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : idle
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        idle(6);
        chk(24'({norm_o, m1_o, m2_o, pd_o}), 24'h00_0008);
        rd(8'h00);
        chk(got, 24'h01_2000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(24'(outs[12:8]), 24'(rows[i].o[12:8]));
            chk(24'(outs[7:0]), 24'(rows[i].o[7:0]));
            rd(rows[i].a);
            chk(got, rows[i].r);
        end
        @(posedge ref_clk_i);
        lock_i <= 1'b0;
        ext_i <= 1'b1;
        idle(6);
        rd(8'h00);
        chk(got, 24'h00_A200);
        @(posedge ref_clk_i);
        lock_i <= 1'b1;
        ext_i <= 1'b0;
        idle(6);
        wr(8'h00, 24'h00_0100);
        chk(24'({stby_o, norm_o}), 24'h00_0002);
        rd(8'h00);
        chk(got, 24'h01_0000);
        @(posedge ref_clk_i);
        wk1_i <= 1'b1;
        for (int k = 0; k < 12 && wev_o !== 1'b1; k++) idle(1);
        chk(24'({wev_o, norm_o}), 24'h00_0003);
        @(posedge ref_clk_i);
        wk1_i <= 1'b0;
        idle(6);
        wr(8'h00, 24'h00_0300);
        @(posedge ref_clk_i);
        wk1_i <= 1'b1;
        idle(12);
        chk(24'(norm_o), 24'h00_0000);
        @(posedge ref_clk_i);
        wk2_i <= 1'b1;
        for (int k = 0; k < 12 && wev_o !== 1'b1; k++) idle(1);
        chk(24'({wev_o, norm_o}), 24'h00_0003);
        // Standby with quiet pins, then a mid-run reset must restore Normal
        @(posedge ref_clk_i);
        wk1_i <= 1'b0;
        wk2_i <= 1'b0;
        idle(6);
        wr(8'h00, 24'h00_0500);
        chk(24'({norm_o, m1_o, m2_o}), 24'h00_0001);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        idle(1);
        chk(24'({norm_o, m1_o, m2_o, pd_o}), 24'h00_0008);
        idle(4);
        rd(8'h00);
        chk(got, 24'h01_2000);
        tally_and_finish();
    end
endmodule : tb
